// [verilog/bhi_pkg.sv]
// constants shared by the brake, horn and inhibit control block
// assumes a single 50 MHz clock and an apb register port
package bhi_pkg;
	// register byte addresses
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_INH_SPEED = 12'h004;
	localparam logic [11:0] ADDR_BRAKE_DELAY = 12'h008;
	localparam logic [11:0] ADDR_HOLD_VOLT = 12'h00C;
	localparam logic [11:0] ADDR_STATUS = 12'h010;
	// control register fields
	localparam int CTRL_TYPE_LSB = 0;
	localparam int CTRL_FCHK_BIT = 3;
	localparam int CTRL_BLIGHT_BIT = 4;
	localparam int CTRL_FBEEP_BIT = 5;
	localparam int CTRL_RBEEP_BIT = 6;
	localparam int CTRL_CONST_BIT = 7;
	// status register fields
	localparam int STAT_INH_BIT = 0;
	localparam int STAT_STATE_LSB = 1;
	localparam int STAT_BFAULT_BIT = 5;
	localparam int STAT_HORN_BIT = 6;
	localparam int STAT_LIGHT_BIT = 7;
	// values after reset
	localparam logic [7:0] CTRL_RST = 8'h08;
	localparam logic [6:0] INH_SPEED_RST = 7'h64;
	localparam logic [9:0] DELAY_RST = 10'h0C8;
	localparam logic [4:0] HOLD_RST = 5'h0C;
	// ranges
	localparam logic [6:0] PCT_MAX = 7'h64;
	localparam logic [9:0] DELAY_MAX_MS = 10'h3E8;
	localparam logic [4:0] HOLD_MIN_V = 5'h0A;
	localparam logic [4:0] HOLD_MAX_V = 5'h18;
	localparam logic [4:0] PEAK_V = 5'h18;
	// timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int MS_NS = 1000000;
	localparam int TICK_CYCLES = MS_NS / CLK_PERIOD_NS;
	localparam logic [10:0] PEAK_TIME_MS = 11'h3E8;
	localparam logic [10:0] LIGHT_HOLD_MS = 11'h7D0;
	localparam logic [10:0] BEEP_HALF_MS = 11'h1F4;
	typedef enum logic [3:0] {
		BHI_ENGAGED = 4'h1,
		BHI_PEAK = 4'h2,
		BHI_HOLD = 4'h4,
		BHI_DELAY = 4'h8
	} bhi_brake_type;
endpackage : bhi_pkg

// [verilog/bhi_inhibit_decode.sv]
// decodes the inhibit input against the selected polarity
// assumes the sense inputs are already synchronous, low and high exclusive
`timescale 1ns/1ps
module bhi_inhibit_decode import bhi_pkg::*; (
	input wire logic [2:0] inhibit_type, // polarity selection 0..5
	input wire logic sense_low, // input pulled to battery minus
	input wire logic sense_high, // input pulled to battery plus
	output logic active // inhibit condition met
);
	logic sense_open;
	assign sense_open = !sense_low && !sense_high;
	always_comb begin
		case (inhibit_type)
			3'h0: active = sense_low;
			3'h1: active = sense_high;
			3'h2: active = sense_open;
			3'h3: active = !sense_low;
			3'h4: active = !sense_high;
			3'h5: active = !sense_open;
			// unused codes never inhibit
			default: active = 1'b0;
		endcase
	end
endmodule : bhi_inhibit_decode

// [verilog/bhi_tick_gen.sv]
// millisecond tick and one hertz square wave
// assumes the clock runs at the rate the tick count is built for
`timescale 1ns/1ps
module bhi_tick_gen import bhi_pkg::*; #(
	parameter int TICK_LEN = TICK_CYCLES
) (
	input wire logic ref_clk, // system clock
	input wire logic resetn, // synchronous reset, active low
	output logic ms_tick, // one-cycle pulse each millisecond
	output logic tone_1hz // square wave, one second period
);
	localparam int PW = $clog2(TICK_LEN + 1);
	logic [PW-1:0] pre_cnt;
	logic [10:0] half_cnt;
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			pre_cnt <= '0;
			ms_tick <= 1'b0;
		end else if (pre_cnt == PW'(TICK_LEN - 1)) begin
			pre_cnt <= '0;
			ms_tick <= 1'b1;
		end else begin
			pre_cnt <= pre_cnt + 1'b1;
			ms_tick <= 1'b0;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			half_cnt <= '0;
			tone_1hz <= 1'b0;
		end else if (ms_tick) begin
			if (half_cnt == BEEP_HALF_MS - 11'h1) begin
				half_cnt <= '0;
				tone_1hz <= !tone_1hz;
			end else begin
				half_cnt <= half_cnt + 11'h1;
			end
		end
	end
endmodule : bhi_tick_gen

// [verilog/bhi_top.sv]
// brake sequencing, horn output and speed inhibit control with apb registers
// assumes vehicle inputs are synchronous to ref_clk and a zero-wait apb master
//
// Contract
// - six inhibit polarities, three active, three inactive
// - clamp speed to inhibit percentage while inhibited
// - inhibit percentage zero stops all driving
// - programmable brake engage delay after zero speed
// - brake fault check only when enabled
// - peak coil drive one second, then hold
// - brake-light mode turns horn into light
// - light on at neutral, off 2s after engage
// - light mode off means ordinary horn
// - fault beep repeats status fault pattern
// - fault pattern beats reverse alert
// - reverse alert while reversing or switch set
// - reverse alert steady or one hertz
`timescale 1ns/1ps
module bhi_top import bhi_pkg::*; #(
	parameter int TICK_LEN = TICK_CYCLES
) (
	input wire logic ref_clk, // system clock, 50 MHz
	input wire logic resetn, // synchronous reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb write
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic inh_sense_low, // inhibit input tied to battery minus
	input wire logic inh_sense_high, // inhibit input tied to battery plus
	input wire logic [6:0] throttle_pct, // requested speed 0..100 percent
	input wire logic throttle_reverse, // request is in reverse
	input wire logic reverse_switch, // reverse switch on the vehicle
	input wire logic horn_button, // operator horn request
	input wire logic fault_present, // any fault present
	input wire logic fault_pattern, // fault code blink level of status lamp
	input wire logic brake_coil_ok, // brake coil sensed healthy
	output logic [6:0] speed_cmd, // speed command after limits
	output logic drive_inhibit, // driving prevented
	output logic inhibit_active, // speed inhibit mode
	output logic brake_coil_on, // brake released, coil driven
	output logic [4:0] coil_volts, // coil drive level in volts
	output logic brake_fault, // brake fault latched
	output logic horn_out // horn or brake light driver
);
	logic [7:0] ctrl;
	logic [6:0] inh_speed;
	logic [9:0] brake_delay;
	logic [4:0] hold_volt;
	logic inh_raw;
	logic ms_tick;
	logic tone_1hz;
	logic setup_phase;
	logic wr_en;
	logic [31:0] next_prdata;
	logic [6:0] next_speed;
	bhi_brake_type brake_state;
	bhi_brake_type next_brake_state;
	logic [10:0] brake_ms;
	logic [10:0] light_ms;
	logic light_on;
	logic was_neutral;
	logic reversing;
	logic bfault_clr;

	function automatic logic addr_hit(input logic [11:0] a);
		addr_hit = (a == ADDR_CTRL) || (a == ADDR_INH_SPEED) || (a == ADDR_BRAKE_DELAY) ||
			(a == ADDR_HOLD_VOLT) || (a == ADDR_STATUS);
	endfunction : addr_hit

	bhi_inhibit_decode u_inh (
		.inhibit_type(ctrl[CTRL_TYPE_LSB +: 3]),
		.sense_low(inh_sense_low),
		.sense_high(inh_sense_high),
		.active(inh_raw)
	);

	bhi_tick_gen #(
		.TICK_LEN(TICK_LEN)
	) u_tick (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.ms_tick(ms_tick),
		.tone_1hz(tone_1hz)
	);

	// apb: zero wait, read data and error captured in the setup cycle
	assign setup_phase = psel && !penable;
	assign wr_en = psel && penable && pwrite && pready && !pslverr;
	assign bfault_clr = wr_en && (paddr == ADDR_STATUS) && pwdata[STAT_BFAULT_BIT];

	always_comb begin
		next_prdata = 32'h0;
		case (paddr)
			ADDR_CTRL: next_prdata[7:0] = ctrl;
			ADDR_INH_SPEED: next_prdata[6:0] = inh_speed;
			ADDR_BRAKE_DELAY: next_prdata[9:0] = brake_delay;
			ADDR_HOLD_VOLT: next_prdata[4:0] = hold_volt;
			ADDR_STATUS: begin
				next_prdata[STAT_INH_BIT] = inhibit_active;
				next_prdata[STAT_STATE_LSB +: 4] = brake_state;
				next_prdata[STAT_BFAULT_BIT] = brake_fault;
				next_prdata[STAT_HORN_BIT] = horn_out;
				next_prdata[STAT_LIGHT_BIT] = light_on;
			end
			default: next_prdata = 32'h0;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= 1'b1;
			if (setup_phase) begin
				pslverr <= !addr_hit(paddr);
				prdata <= pwrite ? 32'h0 : next_prdata;
			end
		end
	end

	// out-of-range writes to the speed, delay and hold registers saturate; ctrl is stored as written, unused inhibit codes included
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ctrl <= CTRL_RST;
			inh_speed <= INH_SPEED_RST;
			brake_delay <= DELAY_RST;
			hold_volt <= HOLD_RST;
		end else if (wr_en) begin
			case (paddr)
				ADDR_CTRL: ctrl <= pwdata[7:0];
				ADDR_INH_SPEED: inh_speed <= (pwdata[31:0] > 32'(PCT_MAX)) ? PCT_MAX : pwdata[6:0];
				ADDR_BRAKE_DELAY:
					brake_delay <= (pwdata[31:0] > 32'(DELAY_MAX_MS)) ? DELAY_MAX_MS : pwdata[9:0];
				ADDR_HOLD_VOLT: begin
					if (pwdata[31:0] < 32'(HOLD_MIN_V)) begin
						hold_volt <= HOLD_MIN_V;
					end else if (pwdata[31:0] > 32'(HOLD_MAX_V)) begin
						hold_volt <= HOLD_MAX_V;
					end else begin
						hold_volt <= pwdata[4:0];
					end
				end
				default: ;
			endcase
		end
	end

	// inhibit mode and speed clamp
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			inhibit_active <= 1'b0;
		end else begin
			inhibit_active <= inh_raw;
		end
	end

	always_comb begin
		next_speed = throttle_pct;
		if (throttle_pct > PCT_MAX) begin
			next_speed = PCT_MAX;
		end
		if (inhibit_active && (next_speed > inh_speed)) begin
			next_speed = inh_speed;
		end
		if (brake_fault || (inhibit_active && inh_speed == 7'h00)) begin
			next_speed = 7'h00;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			speed_cmd <= 7'h00;
			drive_inhibit <= 1'b0;
		end else begin
			speed_cmd <= next_speed;
			drive_inhibit <= brake_fault || (inhibit_active && inh_speed == 7'h00);
		end
	end

	// brake fault: sticky, cleared by writing one, a new fault wins over the clear
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			brake_fault <= 1'b0;
		end else if (ctrl[CTRL_FCHK_BIT] && !brake_coil_ok) begin
			brake_fault <= 1'b1;
		end else if (bfault_clr) begin
			brake_fault <= 1'b0;
		end
	end

	// brake sequencer, times counted in milliseconds
	always_comb begin
		next_brake_state = brake_state;
		case (brake_state)
			BHI_ENGAGED: begin
				if (speed_cmd != 7'h00) begin
					next_brake_state = BHI_PEAK;
				end
			end
			BHI_PEAK: begin
				if (speed_cmd == 7'h00) begin
					next_brake_state = BHI_DELAY;
				end else if (ms_tick && brake_ms == PEAK_TIME_MS - 11'h1) begin
					next_brake_state = BHI_HOLD;
				end
			end
			BHI_HOLD: begin
				if (speed_cmd == 7'h00) begin
					next_brake_state = BHI_DELAY;
				end
			end
			BHI_DELAY: begin
				if (speed_cmd != 7'h00) begin
					next_brake_state = BHI_HOLD;
				end else if (brake_ms >= {1'b0, brake_delay}) begin
					next_brake_state = BHI_ENGAGED;
				end
			end
			default: next_brake_state = BHI_ENGAGED;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			brake_state <= BHI_ENGAGED;
			brake_ms <= 11'h0;
		end else begin
			brake_state <= next_brake_state;
			if (next_brake_state != brake_state) begin
				brake_ms <= 11'h0;
			end else if (ms_tick && brake_ms != 11'h7FF) begin
				brake_ms <= brake_ms + 11'h1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			brake_coil_on <= 1'b0;
			coil_volts <= 5'h00;
		end else begin
			brake_coil_on <= (next_brake_state != BHI_ENGAGED);
			case (next_brake_state)
				BHI_PEAK: coil_volts <= PEAK_V;
				BHI_HOLD, BHI_DELAY: coil_volts <= hold_volt;
				default: coil_volts <= 5'h00;
			endcase
		end
	end

	// brake light: lit from return to neutral until the hold time after engage
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			light_on <= 1'b0;
			light_ms <= 11'h0;
			was_neutral <= 1'b1;
		end else begin
			was_neutral <= (throttle_pct == 7'h00);
			if (!ctrl[CTRL_BLIGHT_BIT] || throttle_pct != 7'h00) begin
				light_on <= 1'b0;
				light_ms <= 11'h0;
			end else if (!was_neutral) begin
				light_on <= 1'b1;
				light_ms <= 11'h0;
			end else if (light_on && brake_state == BHI_ENGAGED && ms_tick) begin
				if (light_ms == LIGHT_HOLD_MS - 11'h1) begin
					light_on <= 1'b0;
				end else begin
					light_ms <= light_ms + 11'h1;
				end
			end
		end
	end

	// horn output selection
	assign reversing = reverse_switch || (throttle_reverse && speed_cmd != 7'h00);

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			horn_out <= 1'b0;
		end else if (ctrl[CTRL_BLIGHT_BIT]) begin
			// fault beeps are dropped here; a relay load cannot beep usefully
			horn_out <= light_on;
		end else if (ctrl[CTRL_FBEEP_BIT] && fault_present) begin
			horn_out <= fault_pattern;
		end else if (ctrl[CTRL_RBEEP_BIT] && reversing) begin
			horn_out <= ctrl[CTRL_CONST_BIT] || tone_1hz;
		end else begin
			horn_out <= horn_button;
		end
	end
endmodule : bhi_top

// [tb/bhi_chk.sv]
// assertions on the outputs of the brake, horn and inhibit block
// assumes binding into bhi_top, one clock domain
`timescale 1ns/1ps
module bhi_chk import bhi_pkg::*; #(
	parameter int TICK_LEN = TICK_CYCLES
) (
	input wire logic ref_clk, // clock
	input wire logic resetn, // reset, active low
	input wire logic [6:0] throttle_pct, // request
	input wire logic [6:0] speed_cmd, // limited speed
	input wire logic drive_inhibit, // no drive
	input wire logic inhibit_active, // inhibit mode
	input wire logic brake_coil_on, // brake released
	input wire logic [4:0] coil_volts, // coil level
	input wire logic brake_fault, // fault latched
	input wire logic horn_out // horn or light
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	chk_speed_bound: assert property (speed_cmd <= $past(throttle_pct))
		else $error("speed above request");
	chk_speed_pass: assert property (!inhibit_active && !brake_fault ##1 !brake_fault |->
		speed_cmd == (($past(throttle_pct) > PCT_MAX) ? PCT_MAX : $past(throttle_pct)))
		else $error("speed not passed through");
	chk_inh_stop: assert property (drive_inhibit |-> speed_cmd == 7'h00)
		else $error("speed while drive prevented");
	chk_peak_start: assert property ($rose(brake_coil_on) |->
		coil_volts == PEAK_V && $past(speed_cmd) != 7'h00)
		else $error("release without peak or request");
	chk_coil_idle: assert property (!brake_coil_on |-> coil_volts == 5'h00)
		else $error("coil driven while engaged");
	chk_hold_range: assert property (brake_coil_on |->
		coil_volts inside {[HOLD_MIN_V:HOLD_MAX_V]})
		else $error("coil level out of range");
	chk_fault_stop: assert property (brake_fault |=> drive_inhibit && speed_cmd == 7'h00)
		else $error("driving with brake fault");
	chk_engage_zero: assert property ($fell(brake_coil_on) |-> $past(speed_cmd) == 7'h00)
		else $error("engaged with speed commanded");
	cov_release: cover property ($rose(brake_coil_on));
	cov_fault: cover property ($rose(brake_fault));
	cov_horn: cover property ($rose(horn_out));
endmodule : bhi_chk

bind bhi_top bhi_chk #(.TICK_LEN(TICK_LEN)) u_chk (.ref_clk(ref_clk), .resetn(resetn),
	.throttle_pct(throttle_pct), .speed_cmd(speed_cmd), .drive_inhibit(drive_inhibit),
	.inhibit_active(inhibit_active), .brake_coil_on(brake_coil_on), .coil_volts(coil_volts),
	.brake_fault(brake_fault), .horn_out(horn_out));

// [tb/bhi_vehicle.sv]
// vehicle side: brake coil and its health sense
// assumes coil drive from bhi_top, coil break set by the bench
`timescale 1ns/1ps
module bhi_vehicle (
	input wire logic brake_coil_on, // coil driven
	input wire logic [4:0] coil_volts, // coil level
	input wire logic coil_open, // bench breaks the coil
	output logic brake_coil_ok, // coil sense
	output logic brake_released // armature pulled in
);
	// an open coil reads unhealthy whatever the drive
	assign brake_coil_ok = !coil_open;
	// armature holds only from ten volts up
	assign brake_released = brake_coil_on && coil_volts >= 5'h0A && !coil_open;
endmodule : bhi_vehicle

// [tb/tb_top.sv]
// self-checking bench for bhi_top with apb master and vehicle model
// assumes a short tick so long timings stay cheap
`timescale 1ns/1ps
module tb_top import bhi_pkg::*;;
	logic ref_clk, resetn = 0, psel = 0, penable = 0, pwrite = 0, pready, er, pslverr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic lo = 0, hi = 0, rt = 0, rs = 0, hb = 0, fp = 0, fpat = 0, bad = 0, ok;
	logic [6:0] thr = 7'h00, speed_cmd;
	logic drive_inhibit, inhibit_active, brake_coil_on, brake_fault, horn_out;
	logic [4:0] coil_volts;
	logic [31:0] rv [5] = '{32'(CTRL_RST), 32'(INH_SPEED_RST), 32'(DELAY_RST),
		32'(HOLD_RST), 32'h2};
	int fail_count = 0, n_tests = 0, seed = 32'hf16b83c3, p, s, k;
	bit ia;
	bhi_top #(.TICK_LEN(4)) uut (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .inh_sense_low(lo), .inh_sense_high(hi),
		.throttle_pct(thr), .throttle_reverse(rt), .reverse_switch(rs), .horn_button(hb),
		.fault_present(fp), .fault_pattern(fpat), .brake_coil_ok(ok), .speed_cmd(speed_cmd),
		.drive_inhibit(drive_inhibit), .inhibit_active(inhibit_active),
		.brake_coil_on(brake_coil_on), .coil_volts(coil_volts), .brake_fault(brake_fault),
		.horn_out(horn_out));
	bhi_vehicle veh (.brake_coil_on(brake_coil_on), .coil_volts(coil_volts),
		.coil_open(bad), .brake_coil_ok(ok), .brake_released());
	initial begin
		ref_clk = 0;
		forever #10 ref_clk = ~ref_clk;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// entered just after an edge; holds the request until pready is sampled
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : apb
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc
	function automatic bit inh_m(int t, bit l, bit h);
		case (t)
			0: return l;
			1: return h;
			2: return !l && !h;
			3: return !l;
			4: return !h;
			5: return l || h;
			default: return 0;
		endcase
	endfunction : inh_m
	task automatic print_verdict;
		if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : print_verdict
	initial begin
		cyc(50000);
		fail_count++;
		print_verdict();
	end
	initial begin
		cyc(16);
		resetn <= 1'b1;
		cyc(2);
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, 12'(i * 4), 32'h0);
			chk("reset value", rv[i], rd);
		end
		apb(1'b0, 12'h020, 32'h0);
		chk("unmapped", 32'h1, er);
		for (int t = 0; t < 8; t++) begin
			for (int c = 0; c < 3; c++) begin
				p = (c == 2) ? 0 : $unsigned($random(seed)) % 101;
				s = $unsigned($random(seed)) % 101;
				apb(1'b1, ADDR_CTRL, 32'(t));
				apb(1'b1, ADDR_INH_SPEED, 32'(p));
				lo <= (c == 0);
				hi <= (c == 1);
				thr <= 7'(s);
				cyc(4);
				ia = inh_m(t, c == 0, c == 1);
				chk("inhibit", ia, inhibit_active);
				chk("speed", (ia && p < s) ? p : s, speed_cmd);
				if (ia && p == 0) chk("no drive", 32'h1, drive_inhibit);
			end
		end
		thr <= 7'h00;
		apb(1'b1, ADDR_BRAKE_DELAY, 32'h5);
		apb(1'b1, ADDR_HOLD_VOLT, 32'h0F);
		cyc(900);
		thr <= 7'h32;
		cyc(3);
		chk("peak", PEAK_V, coil_volts);
		cyc(3900);
		chk("peak", PEAK_V, coil_volts);
		cyc(200);
		chk("hold", 32'h0F, coil_volts);
		thr <= 7'h00;
		cyc(10);
		chk("delay", 32'h1, brake_coil_on);
		cyc(30);
		chk("engage", 32'h0, brake_coil_on);
		apb(1'b1, ADDR_CTRL, 32'h0);
		bad <= 1'b1;
		cyc(5);
		chk("fault off", 32'h0, brake_fault);
		apb(1'b1, ADDR_CTRL, 32'h08);
		cyc(3);
		chk("fault on", 32'h1, brake_fault);
		chk("fault stop", 32'h1, drive_inhibit);
		bad <= 1'b0;
		apb(1'b1, ADDR_STATUS, 32'h20);
		cyc(2);
		chk("fault clear", 32'h0, brake_fault);
		hb <= 1'b1;
		cyc(3);
		chk("horn", 32'h1, horn_out);
		hb <= 1'b0;
		apb(1'b1, ADDR_CTRL, 32'hC0);
		rs <= 1'b1;
		cyc(3);
		chk("steady", 32'h1, horn_out);
		apb(1'b1, ADDR_CTRL, 32'h40);
		k = 0;
		repeat (4000) begin
			@(posedge ref_clk);
			k += (horn_out === 1'b1);
		end
		chk("pulsed", 32'h1, k > 1900 && k < 2100);
		apb(1'b1, ADDR_CTRL, 32'hC0);
		rs <= 1'b0;
		rt <= 1'b1;
		thr <= 7'h1E;
		cyc(4);
		chk("reversing", 32'h1, horn_out);
		thr <= 7'h00;
		cyc(4);
		chk("stopped", 32'h0, horn_out);
		apb(1'b1, ADDR_CTRL, 32'hE0);
		rs <= 1'b1;
		fp <= 1'b1;
		cyc(3);
		chk("fault over rev", 32'h0, horn_out);
		fpat <= 1'b1;
		cyc(3);
		chk("fault beep", 32'h1, horn_out);
		fp <= 1'b0;
		rs <= 1'b0;
		rt <= 1'b0;
		apb(1'b1, ADDR_CTRL, 32'h10);
		hb <= 1'b1;
		thr <= 7'h32;
		cyc(5);
		chk("light idle", 32'h0, horn_out);
		thr <= 7'h00;
		cyc(3);
		chk("light on", 32'h1, horn_out);
		cyc(4000);
		chk("light held", 32'h1, horn_out);
		cyc(4300);
		chk("light off", 32'h0, horn_out);
		print_verdict();
	end
endmodule : tb_top
